/* File: hw/psbs_sequencer.sv */
// Phase-shifted full-bridge sequencer: start-up gating, drive timing,
// rectifier dead-time overrides and one-shot overcurrent halt.
// Assumes comparator and lockout levels arrive asynchronously on pins,
// while dead times, period and phase come from logic on ref_clk_in.
`default_nettype none

// Function
// - Lockout keeps every drive inactive
// - Remote off holds all six drives low
// - Remote request ignored during lockout
// - Off state resets soft-start ramp
// - Operation starts only when supply-good low
// - Supply-good follows 32-clock start-up counter
// - Counter delays start only, never stop
// - Four legs, two rectifiers, separate dead times
// - Transfer interval: A, D, F on; E off
// - C follows D-off after second-pair dead time
// - F drops after A-off by rectifier dead time
// - B follows A-off after first-pair dead time
// - Light load forces zero rectifier dead time
// - Current limit zeroes next rectifier dead time
// - Phase-count lag edge restores dead time
// - One-shot overcurrent halts, rectifiers low
module psbs_sequencer #(
    parameter int unsigned DEAD_W   = psbs_pkg::DEAD_W_DEF,
    parameter int unsigned PERIOD_W = psbs_pkg::PERIOD_W_DEF
) (
    input  wire logic                ref_clk_in,
    input  wire logic                nrst_in,
    input  wire logic                undervoltage_lockout_in,
    input  wire logic                remote_on_in,
    input  wire logic                light_load_in,
    input  wire logic                cycle_current_limit_in,
    input  wire logic                one_shot_ocp_in,
    input  wire logic [DEAD_W-1:0]   first_pair_dead_time_in,
    input  wire logic [DEAD_W-1:0]   second_pair_dead_time_in,
    input  wire logic [DEAD_W-1:0]   rectifier_dead_time_in,
    input  wire logic [PERIOD_W-1:0] half_period_in,
    input  wire logic [PERIOD_W-1:0] phase_shift_in,
    output var  psbs_pkg::psbs_drive_s drives_out,
    output logic                     supply_good_n_out,
    output logic                     soft_start_reset_out,
    output logic                     ocp_halt_out
);
    import psbs_pkg::*;

    // Refuse widths the counters cannot serve
    if (DEAD_W < 1 || DEAD_W > 16 || PERIOD_W < 2 || PERIOD_W > 24) begin
        $error("psbs_sequencer: unsupported counter width");
    end

    localparam int unsigned NSYNC = 5;  // Pins passed through synchronisers

    logic [NSYNC-1:0] sync1_ff;          // First stage, read by stage two only
    logic [NSYNC-1:0] sync2_ff;          // Second stage
    logic [NSYNC-1:0] sync3_ff;          // Third stage
    logic [NSYNC-1:0] filt_ff;           // Accepted pin levels
    logic [NSYNC-1:0] pins_raw;          // Raw pin bundle

    logic                 undervoltage_lockout;          // Filtered lockout
    logic                 remote_on;     // Filtered on request
    logic                 light_load;    // Filtered light-load flag
    logic                 ccl;           // Filtered cycle current limit
    logic                 ocp;           // Filtered one-shot overcurrent
    logic                 enable_req;    // Supply valid and on requested

    logic [STARTUP_W-1:0] start_cnt_ff;  // Start-up counter
    logic                 good_n_ff;     // Active-low supply good
    logic                 ocp_ff;        // Overcurrent halt latch
    logic                 run;           // Sequencer may drive
    logic                 active_ff;     // Sequencer was running

    logic [PERIOD_W-1:0]  hcnt_ff;       // Position within half cycle
    logic                 half_ff;       // Zero: A/D half, one: B/C half
    logic [PERIOD_W-1:0]  phase_ff;      // Phase held for one period
    logic                 lag_done_ff;   // Lag pair switched this half
    logic                 lead_ev;       // End of half: lead leg off
    logic                 lag_ev;        // Lag leg off
    logic                 lag_by_ccl;    // Lag edge caused by limit
    logic                 td3_zero_ff;   // Next rectifier edge undelayed
    logic                 rect_zero;     // Rectifier delay forced to zero

    logic [DEAD_W-1:0]    lead_cnt_ff;   // First-pair dead-time timer
    logic                 lead_pend_ff;  // Lead leg waiting to turn on
    logic [DEAD_W-1:0]    lag_cnt_ff;    // Second-pair dead-time timer
    logic                 lag_pend_ff;   // Lag leg waiting to turn on
    logic [DEAD_W-1:0]    rect_cnt_ff;   // Rectifier dead-time timer
    logic                 rect_pend_ff;  // Rectifier waiting to turn off
    logic                 lead_fire;     // Lead dead time elapsed
    logic                 lag_fire;      // Lag dead time elapsed
    logic                 rect_fire;     // Rectifier dead time elapsed

    psbs_drive_s          drv_ff;        // Registered drives

    assign pins_raw = {one_shot_ocp_in, cycle_current_limit_in,
                       light_load_in, remote_on_in,
                       undervoltage_lockout_in};

    // Three-stage synchronisers; a change is taken once stages agree
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            filt_ff  <= 5'h01;           // Start in lockout
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < NSYNC; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    filt_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    assign undervoltage_lockout       = filt_ff[0];
    assign remote_on  = filt_ff[1];
    assign light_load = filt_ff[2];
    assign ccl        = filt_ff[3];
    assign ocp        = filt_ff[4];

    // Lockout masks the on request entirely
    assign enable_req = !undervoltage_lockout && remote_on;

    // Start-up counter; only the rising side is delayed
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            start_cnt_ff <= '0;
            good_n_ff    <= 1'b1;
        end else if (!enable_req) begin
            start_cnt_ff <= '0;
            good_n_ff    <= 1'b1;
        end else if (good_n_ff) begin
            if (start_cnt_ff == STARTUP_LAST) begin
                good_n_ff <= 1'b0;
            end else begin
                start_cnt_ff <= start_cnt_ff + 1'b1;
            end
        end
    end

    // One-shot overcurrent latch; cleared only by off or lockout
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ocp_ff <= 1'b0;
        end else if (ocp && !good_n_ff) begin
            ocp_ff <= 1'b1;
        end else if (!enable_req) begin
            ocp_ff <= 1'b0;
        end
    end

    // Stop is immediate on off, lockout or overcurrent
    assign run = enable_req && !good_n_ff && !ocp_ff && !ocp;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= run;
        end
    end

    // Event decode within the running half cycle
    assign lead_ev    = active_ff && run &&
                        (hcnt_ff == half_period_in - 1'b1);
    assign lag_by_ccl = ccl && hcnt_ff != phase_ff;
    assign lag_ev     = active_ff && run && !lag_done_ff && !lead_ev &&
                        (hcnt_ff == phase_ff || ccl);
    assign lead_fire  = lead_pend_ff && lead_cnt_ff == '0;
    assign lag_fire   = lag_pend_ff && lag_cnt_ff == '0;
    assign rect_fire  = rect_pend_ff && rect_cnt_ff == '0;
    assign rect_zero  = light_load || td3_zero_ff;

    // Half-cycle counter; phase taken once per period
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hcnt_ff     <= '0;
            half_ff     <= 1'b0;
            phase_ff    <= '0;
            lag_done_ff <= 1'b0;
        end else if (!(active_ff && run)) begin
            hcnt_ff     <= '0;
            half_ff     <= 1'b0;
            phase_ff    <= phase_shift_in;
            lag_done_ff <= 1'b0;
        end else if (lead_ev) begin
            hcnt_ff     <= '0;
            half_ff     <= !half_ff;
            lag_done_ff <= 1'b0;
            if (half_ff) begin
                phase_ff <= phase_shift_in;
            end
        end else begin
            hcnt_ff <= hcnt_ff + 1'b1;
            if (lag_ev) begin
                lag_done_ff <= 1'b1;
            end
        end
    end

    // Limit-caused lag edge arms a zero delay until a normal lag edge
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            td3_zero_ff <= 1'b0;
        end else if (!run) begin
            td3_zero_ff <= 1'b0;
        end else if (lag_ev) begin
            td3_zero_ff <= lag_by_ccl;
        end
    end

    // Dead-time timers; each loads on its off edge, fires at zero
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lead_cnt_ff  <= '0;
            lead_pend_ff <= 1'b0;
            lag_cnt_ff   <= '0;
            lag_pend_ff  <= 1'b0;
            rect_cnt_ff  <= '0;
            rect_pend_ff <= 1'b0;
        end else if (!run) begin
            lead_pend_ff <= 1'b0;
            lag_pend_ff  <= 1'b0;
            rect_pend_ff <= 1'b0;
        end else begin
            if (lead_ev) begin
                lead_cnt_ff  <= first_pair_dead_time_in;
                lead_pend_ff <= 1'b1;
            end else if (lead_fire) begin
                lead_pend_ff <= 1'b0;
            end else if (lead_pend_ff) begin
                lead_cnt_ff <= lead_cnt_ff - 1'b1;
            end
            if (lag_ev) begin
                lag_cnt_ff  <= second_pair_dead_time_in;
                lag_pend_ff <= 1'b1;
            end else if (lag_fire) begin
                lag_pend_ff <= 1'b0;
            end else if (lag_pend_ff) begin
                lag_cnt_ff <= lag_cnt_ff - 1'b1;
            end
            // Zero delay still costs one edge; keeps E/F glitch-free
            if (lead_ev) begin
                rect_cnt_ff  <= rect_zero ? '0 : rectifier_dead_time_in;
                rect_pend_ff <= 1'b1;
            end else if (rect_fire) begin
                rect_pend_ff <= 1'b0;
            end else if (rect_pend_ff) begin
                rect_cnt_ff <= rect_cnt_ff - 1'b1;
            end
        end
    end

    // Drive registers; bridge off and rectifier on edges act at once, the other edges wait dead time
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drv_ff <= DRIVE_OFF;
        end else if (!run) begin
            drv_ff <= DRIVE_OFF;
        end else if (!active_ff) begin
            drv_ff <= DRIVE_START;
        end else begin
            // Lead pair: A in half zero, B in half one
            if (lead_ev) begin
                if (half_ff) begin
                    drv_ff.b <= 1'b0;
                end else begin
                    drv_ff.a <= 1'b0;
                end
            end else if (lead_fire) begin
                if (half_ff) begin
                    drv_ff.b <= 1'b1;
                end else begin
                    drv_ff.a <= 1'b1;
                end
            end
            // Lag pair: D off in half zero, C off in half one
            if (lag_ev) begin
                if (half_ff) begin
                    drv_ff.c <= 1'b0;
                    drv_ff.f <= 1'b1;                // Secondary short
                end else begin
                    drv_ff.d <= 1'b0;
                    drv_ff.e <= 1'b1;
                end
            end else if (lag_fire) begin
                if (half_ff) begin
                    drv_ff.d <= 1'b1;
                end else begin
                    drv_ff.c <= 1'b1;
                end
            end
            // Half has already toggled when the rectifier fires
            if (rect_fire) begin
                if (half_ff) begin
                    drv_ff.f <= 1'b0;
                end else begin
                    drv_ff.e <= 1'b0;
                end
            end
        end
    end

    // Status outputs, all registered
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            supply_good_n_out    <= 1'b1;
            soft_start_reset_out <= 1'b1;
            ocp_halt_out         <= 1'b0;
        end else begin
            supply_good_n_out    <= good_n_ff;
            soft_start_reset_out <= !enable_req;
            ocp_halt_out         <= ocp_ff;
        end
    end

    assign drives_out = drv_ff;
endmodule : psbs_sequencer
`default_nettype wire

/* File: shared/psbs_pkg.sv */
// Shared constants and types of the phase-shift bridge sequencer.
// Assumes one 20 MHz timing clock and comparator decisions as digital levels.
`default_nettype none
package psbs_pkg;
    // Start-up delay in oscillator clocks
    localparam int unsigned STARTUP_CLOCKS = 32;
    localparam int unsigned STARTUP_W      = 6;
    localparam logic [STARTUP_W-1:0] STARTUP_LAST =
        STARTUP_W'(STARTUP_CLOCKS - 1);
    // Default widths of dead-time and period counts
    localparam int unsigned DEAD_W_DEF   = 8;
    localparam int unsigned PERIOD_W_DEF = 10;
    // Timing clock figures
    localparam int unsigned CLK_PERIOD_NS = 50;

    // The six gate drives, bridge legs a to d and rectifiers e, f
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
        logic e;
        logic f;
    } psbs_drive_s;

    // All drives low
    localparam psbs_drive_s DRIVE_OFF = '{1'b0, 1'b0, 1'b0,
                                          1'b0, 1'b0, 1'b0};
    // Drive pattern at the start of power transfer
    localparam psbs_drive_s DRIVE_START = '{1'b1, 1'b0, 1'b0,
                                            1'b1, 1'b0, 1'b1};
endpackage : psbs_pkg
`default_nettype wire

/* File: test/psbs_gate_buffers.sv */
// Gate drive buffer model standing behind the six sequencer drives.
// Assumes drives are sampled on the sequencer clock.
`default_nettype none
module psbs_gate_buffers (
    input  wire logic                  ref_clk_in,
    input  wire logic                  nrst_in,
    input  wire psbs_pkg::psbs_drive_s drives_in,
    output var  psbs_pkg::psbs_drive_s gates_out,
    output logic [7:0]                 shoot_cnt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import psbs_pkg::*;
    // One clock of buffer delay; switches held off while reset stands
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gates_out <= DRIVE_OFF;
        end else begin
            gates_out <= drives_in;
        end
    end
    // Counts cycles where one bridge leg would short the supply
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shoot_cnt_out <= 8'h00;
        end else if ((gates_out.a & gates_out.b) |
                     (gates_out.c & gates_out.d)) begin
            shoot_cnt_out <= shoot_cnt_out + 8'h01;
        end
    end
endmodule : psbs_gate_buffers
`default_nettype wire

/* File: test/psbs_sequencer_asserts.sv */
// Port checker of the bridge sequencer.
// Assumes it is bound into every sequencer instance.
`default_nettype none
module psbs_sequencer_asserts #(
    parameter int unsigned DEAD_W = psbs_pkg::DEAD_W_DEF
) (
    input wire logic                  ref_clk_in,
    input wire logic                  nrst_in,
    input wire logic                  undervoltage_lockout_in,
    input wire logic                  remote_on_in,
    input wire logic [DEAD_W-1:0]     first_pair_dead_time_in,
    input wire logic [DEAD_W-1:0]     second_pair_dead_time_in,
    input wire logic [DEAD_W-1:0]     rectifier_dead_time_in,
    input wire psbs_pkg::psbs_drive_s drives_out,
    input wire logic                  supply_good_n_out,
    input wire logic                  soft_start_reset_out,
    input wire logic                  ocp_halt_out
);
    import psbs_pkg::*;
    logic [15:0] a_lo_ff;   // Cycles since leg a was high
    logic [15:0] d_lo_ff;   // Cycles since leg d was high
    logic [15:0] en_run_ff; // Cycles both enables have stood
    // Saturating counters, so long idle spells cannot wrap
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            a_lo_ff <= '0;
            d_lo_ff <= '0;
            en_run_ff <= '0;
        end else begin
            a_lo_ff <= drives_out.a ? '0 : a_lo_ff + 16'(a_lo_ff != '1);
            d_lo_ff <= drives_out.d ? '0 : d_lo_ff + 16'(d_lo_ff != '1);
            en_run_ff <= (remote_on_in && !undervoltage_lockout_in) ?
                en_run_ff + 16'(en_run_ff != '1) : '0;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    AST_LOCKOUT: assert property (
        undervoltage_lockout_in [*7] |-> drives_out == DRIVE_OFF
        && supply_good_n_out) else $error("drives active in lockout");
    AST_REMOTE_OFF: assert property (
        !remote_on_in [*6] |-> drives_out == DRIVE_OFF
        && soft_start_reset_out) else $error("drives active when off");
    AST_GOOD_EARLY: assert property (
        $fell(supply_good_n_out) |-> en_run_ff inside {[34:39]})
        else $error("supply good not after start-up count");
    AST_GOOD_LATE: assert property (
        en_run_ff >= 16'd40 && !ocp_halt_out |-> !supply_good_n_out)
        else $error("supply good late");
    AST_START: assert property (
        $fell(supply_good_n_out) |=> drives_out == DRIVE_START)
        else $error("wrong first drive pattern");
    AST_NO_SHOOT: assert property (
        !(drives_out.a && drives_out.b) && !(drives_out.c && drives_out.d))
        else $error("leg overlap");
    AST_FIRST_DEAD: assert property (
        $rose(drives_out.b) |->
        a_lo_ff == 16'(first_pair_dead_time_in) + 16'd1)
        else $error("first pair dead time wrong");
    AST_SECOND_DEAD: assert property (
        $rose(drives_out.c) |->
        d_lo_ff == 16'(second_pair_dead_time_in) + 16'd1)
        else $error("second pair dead time wrong");
    AST_RECT_DEAD: assert property (
        $fell(drives_out.f) && drives_out.c |-> a_lo_ff == 16'd1
        || a_lo_ff == 16'(rectifier_dead_time_in) + 16'd1)
        else $error("rectifier dead time wrong");
    AST_OCP: assert property (
        ocp_halt_out |=> !drives_out.e && !drives_out.f)
        else $error("rectifier on after overcurrent");
endmodule : psbs_sequencer_asserts
bind psbs_sequencer psbs_sequencer_asserts #(.DEAD_W(DEAD_W)) u_chk (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .undervoltage_lockout_in(undervoltage_lockout_in),
    .remote_on_in(remote_on_in), .drives_out(drives_out),
    .first_pair_dead_time_in(first_pair_dead_time_in),
    .second_pair_dead_time_in(second_pair_dead_time_in),
    .rectifier_dead_time_in(rectifier_dead_time_in),
    .supply_good_n_out(supply_good_n_out),
    .soft_start_reset_out(soft_start_reset_out),
    .ocp_halt_out(ocp_halt_out));
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench of the sequencer with the gate buffer model.
// Assumes the checker is bound in by its own file.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import psbs_pkg::*;
    localparam int TD1 = 3;
    localparam int TD2 = 5;
    localparam int TD3 = 7;
    // Drive bit, target bit, target level and gap of each dead time
    localparam int OFF_B[6] = '{5, 2, 5, 4, 3, 4};
    localparam int ON_B[6] = '{4, 3, 0, 5, 2, 1};
    localparam logic [5:0] LVL = 6'h1b;
    localparam int EXP[6] = '{TD1+1, TD2+1, TD3+1, TD1+1, TD2+1, TD3+1};
    logic        clk;
    logic        nrst, undervoltage_lockout, ron, lite, ccl, ocp;
    psbs_drive_s drv;
    logic        good_n, ssr, ocp_halt;
    logic [7:0]  shoots;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          n_w;
    psbs_sequencer uut (
        .ref_clk_in(clk), .nrst_in(nrst), .undervoltage_lockout_in(undervoltage_lockout),
        .remote_on_in(ron), .light_load_in(lite),
        .cycle_current_limit_in(ccl), .one_shot_ocp_in(ocp),
        .first_pair_dead_time_in(8'h03), .second_pair_dead_time_in(8'h05),
        .rectifier_dead_time_in(8'h07), .half_period_in(10'h028),
        .phase_shift_in(10'h00c), .drives_out(drv),
        .supply_good_n_out(good_n), .soft_start_reset_out(ssr),
        .ocp_halt_out(ocp_halt));
    // Lone device: no sync followers hang on this one
    psbs_gate_buffers gb (.ref_clk_in(clk), .nrst_in(nrst), .drives_in(drv),
        .gates_out(), .shoot_cnt_out(shoots));
    // 50 ns free-running clock, no external sync source
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    // Hang guard, well above the eight hundred-odd cycles planned
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait for one drive bit to reach a level
    task automatic wait_bit(input int b, input logic lvl, output int n);
        n = 0;
        while (drv[b] !== lvl && n < 200) begin
            @(negedge clk);
            n = n + 1;
        end
    endtask : wait_bit
    // Cycles from one drive falling to another reaching a level
    task automatic gap(input int off_b, input int on_b, input logic lvl,
                       input int exp);
        int n;
        wait_bit(off_b, 1'b1, n);
        wait_bit(off_b, 1'b0, n);
        wait_bit(on_b, lvl, n);
        check(16'(n), 16'(exp));
    endtask : gap
    // Enable to supply good takes the start-up count plus sync delay
    task automatic startup();
        int n;
        n = 0;
        while (good_n !== 1'b0 && n < 60) begin
            @(negedge clk);
            n = n + 1;
        end
        check(16'(n inside {[35:39]}), 16'h1);
        @(negedge clk);
        check(16'(drv), 16'(DRIVE_START));
        check(16'(ssr), 16'h0);
    endtask : startup
    task automatic halted(input logic [15:0] flags);
        repeat (7) @(negedge clk);
        check(16'(drv), 16'(DRIVE_OFF));
        check({good_n, ssr, ocp_halt}, flags);
    endtask : halted
    initial begin
        nrst = 1'b0;
        undervoltage_lockout = 1'b1;
        ron = 1'b1;
        lite = 1'b0;
        ccl = 1'b0;
        ocp = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        ron = 1'b0;
        halted(16'h6);
        repeat (3) @(negedge clk);
        ron = 1'b1;
        repeat (50) @(negedge clk);
        halted(16'h6);
        $display("test lockout done");
        undervoltage_lockout = 1'b0;
        startup();
        for (int i = 0; i < 6; i++) begin
            gap(OFF_B[i], ON_B[i], LVL[i], EXP[i]);
        end
        $display("test dead times done");
        lite = 1'b1;
        repeat (10) @(negedge clk);
        gap(5, 0, 1'b0, 1);
        lite = 1'b0;
        repeat (10) @(negedge clk);
        gap(5, 0, 1'b0, TD3 + 1);
        $display("test light load done");
        wait_bit(5, 1'b0, n_w);
        wait_bit(5, 1'b1, n_w);
        ccl = 1'b1;
        repeat (6) @(negedge clk);
        ccl = 1'b0;
        gap(5, 0, 1'b0, 1);
        gap(5, 0, 1'b0, TD3 + 1);
        $display("test current limit done");
        ron = 1'b0;
        halted(16'h6);
        ron = 1'b1;
        startup();
        undervoltage_lockout = 1'b1;
        halted(16'h6);
        ron = 1'b0;
        repeat (5) @(negedge clk);
        ron = 1'b1;
        halted(16'h6);
        undervoltage_lockout = 1'b0;
        startup();
        $display("test off and lockout done");
        ocp = 1'b1;
        repeat (6) @(negedge clk);
        ocp = 1'b0;
        repeat (40) @(negedge clk);
        check(16'({drv, ocp_halt}), 16'h1);
        ron = 1'b0;
        halted(16'h6);
        ron = 1'b1;
        startup();
        check(16'(shoots), 16'h0);
        $display("test overcurrent done");
        conclude();
    end
endmodule : tb
`default_nettype wire
